// File: design/dps_pkg.sv
// package: constants for dma channel peripheral signalling
`default_nettype none
package dps_pkg;
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned START_DLY_NOCHAIN = 39;
	localparam int unsigned START_DLY_ARRAY = 59;
	localparam int unsigned START_DLY_LINKED = 61;
	localparam logic [7:0] DLY_NOCHAIN = 8'h27;
	localparam logic [7:0] DLY_ARRAY = 8'h3b;
	localparam logic [7:0] DLY_LINKED = 8'h3d;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CFG = 8'h04;
	localparam logic [7:0] ADDR_COUNT = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_CODES = 8'h10;
	localparam int CTRL_START = 0;
	localparam int CTRL_ABORT_CLR = 1;
	localparam int CFG_PCL_LO = 0;
	localparam int CFG_CHAIN_LO = 2;
	localparam int CFG_SINGLE = 4;
	localparam int CFG_ITEM_WIDTH = 5;
	localparam int CFG_PORT_WIDTH = 6;
	localparam int CFG_BURST = 7;
	localparam int CFG_ENABLE_CLK = 8;
	localparam logic [1:0] PCL_STATUS = 2'h0;
	localparam logic [1:0] PCL_START = 2'h2;
	localparam logic [1:0] PCL_ABORT = 2'h3;
	localparam logic [1:0] CHAIN_NONE = 2'h0;
	localparam logic [1:0] CHAIN_ARRAY = 2'h2;
	localparam logic [1:0] CHAIN_LINKED = 2'h3;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [8:0] CODES_RESET = 9'h000;
	typedef enum logic [2:0] {DPS_IDLE, DPS_REQ, DPS_INIT, DPS_XFER, DPS_WAITE} dps_state_e;
endpackage : dps_pkg
`default_nettype wire

// File: design/dps_start_delay.sv
// start pulse delay counter
`default_nettype none
module dps_start_delay
	import dps_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic arm,
	input wire logic [7:0] delay,
	output logic fire
);
	logic [7:0] cnt_reg, cnt_next;
	logic run_reg, run_next;
	always_comb begin
		cnt_next = cnt_reg;
		run_next = run_reg;
		fire = 1'b0;
		if (arm) begin
			cnt_next = delay - 8'h01;
			run_next = 1'b1;
		end else if (run_reg) begin
			if (cnt_reg == 8'h00) begin
				fire = 1'b1;
				run_next = 1'b0;
			end
			cnt_next = cnt_reg - 8'h01;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_reg <= 8'h00;
			run_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			run_reg <= run_next;
		end
	end
endmodule // dps_start_delay
`default_nettype wire

// File: design/dps_channel.sv
// dma channel peripheral and system signalling, apb registers
`default_nettype none
module dps_channel
	import dps_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic peripheral_control_line_in,
	output logic peripheral_control_line_out,
	output logic peripheral_control_line_oe,
	input wire logic xfer_req_n,
	output logic periph_ack_n,
	output logic end_of_transfer_n,
	output logic data_transfer_complete_n,
	input wire logic [15:0] periph_data_in,
	output logic [15:0] read_data,
	input wire logic byte_addr_odd,
	input wire logic diagonal_word,
	output logic high_lane_steer_n,
	output logic bus_request_out_n,
	input wire logic bus_grant_n,
	input wire logic bus_busy_n,
	output logic grant_acknowledge_n,
	output logic address_strobe_n,
	input wire logic dtack_n,
	input wire logic [2:0] bus_exception_code_n,
	output logic [2:0] function_code_lines,
	output logic busy
);

	logic [8:0] cfg_reg, cfg_next;
	logic [15:0] transfer_counter_reg, transfer_counter_next;
	logic [8:0] codes_reg, codes_next;
	logic abort_err_reg, abort_err_next;
	logic cfg_err_reg, cfg_err_next;
	logic bus_err_reg, bus_err_next;
	logic done_reg, done_next;
	logic [31:0] prdata_reg, prdata_next;
	dps_state_e st_reg, st_next;
	logic br_reg, br_next;
	logic grant_acknowledge_reg, grant_acknowledge_next;
	logic as_reg, as_next;
	logic ack_reg, ack_next;
	logic eot_reg, eot_next;
	logic dtc_reg, dtc_next;
	logic hib_reg, hib_next;
	logic [2:0] fc_reg, fc_next;
	logic [15:0] rdata_reg, rdata_next;
	logic pcl_prev_reg, ecl_prev_reg;
	logic pulse_reg, pulse_next;
	logic arm, fire, wr_en, rd_en, abort_ev, e_fall, cfg_bad;
	logic [7:0] dly;
	logic [1:0] pcl_mode, chain;
	assign pcl_mode = cfg_reg[CFG_PCL_LO +: 2];
	assign chain = cfg_reg[CFG_CHAIN_LO +: 2];
	assign wr_en = psel && penable && pwrite;
	// read data loads in the setup phase so it stands when pready is sampled
	assign rd_en = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = prdata_reg;
	assign abort_ev = (pcl_mode == PCL_ABORT) && pcl_prev_reg && !peripheral_control_line_in;
	assign e_fall = ecl_prev_reg && !peripheral_control_line_in;
	// single addressing with mismatched widths, or word items on diagonal words, refused at start
	assign cfg_bad = (cfg_reg[CFG_SINGLE] && (cfg_reg[CFG_ITEM_WIDTH] != cfg_reg[CFG_PORT_WIDTH]))
		|| (cfg_reg[CFG_ITEM_WIDTH] && diagonal_word);
	assign arm = wr_en && (paddr == ADDR_CTRL) && pwdata[CTRL_START];
	always_comb begin
		case (chain)
			CHAIN_ARRAY: dly = DLY_ARRAY;
			CHAIN_LINKED: dly = DLY_LINKED;
			default: dly = DLY_NOCHAIN;
		endcase
	end

	dps_start_delay u_dly (
		.clk(clk),
		.rst_n(rst_n),
		.arm(arm),
		.delay(dly),
		.fire(fire)
	);

	// one cycle is the shortest pulse a single clock can make
	assign peripheral_control_line_out = !pulse_reg;
	assign peripheral_control_line_oe = pulse_reg;
	assign busy = (st_reg != DPS_IDLE);
	assign bus_request_out_n = !br_reg;
	assign grant_acknowledge_n = !grant_acknowledge_reg;
	assign address_strobe_n = !as_reg;
	assign periph_ack_n = !ack_reg;
	assign end_of_transfer_n = !eot_reg;
	assign data_transfer_complete_n = !dtc_reg;
	assign high_lane_steer_n = !hib_reg;
	assign function_code_lines = fc_reg;
	assign read_data = rdata_reg;

	always_comb begin
		cfg_next = cfg_reg;
		transfer_counter_next = transfer_counter_reg;
		codes_next = codes_reg;
		abort_err_next = abort_err_reg;
		cfg_err_next = cfg_err_reg;
		bus_err_next = bus_err_reg;
		done_next = done_reg;
		prdata_next = prdata_reg;
		st_next = st_reg;
		br_next = br_reg;
		grant_acknowledge_next = grant_acknowledge_reg;
		as_next = 1'b0;
		ack_next = 1'b0;
		eot_next = 1'b0;
		dtc_next = 1'b0;
		hib_next = 1'b0;
		fc_next = fc_reg;
		rdata_next = rdata_reg;
		pulse_next = fire && (pcl_mode == PCL_START);
		if (wr_en) begin
			case (paddr)
				ADDR_CTRL: begin
					if (pwdata[CTRL_ABORT_CLR]) begin
						abort_err_next = 1'b0;
						cfg_err_next = 1'b0;
						bus_err_next = 1'b0;
						done_next = 1'b0;
					end
				end
				ADDR_CFG: cfg_next = pwdata[8:0];
				ADDR_COUNT: transfer_counter_next = pwdata[15:0];
				ADDR_CODES: codes_next = pwdata[8:0];
				default: ;
			endcase
		end

		if (rd_en) begin
			case (paddr)
				ADDR_CFG: prdata_next = {24'h000000, cfg_reg[7:0]};
				ADDR_COUNT: prdata_next = {24'h000000, transfer_counter_reg[7:0]};
				ADDR_STATUS: prdata_next = {24'h000000, 3'h0, busy, bus_err_reg, cfg_err_reg, abort_err_reg, done_reg};
				ADDR_CODES: prdata_next = {24'h000000, codes_reg[7:0]};
				default: prdata_next = 32'h00000000;
			endcase
		end

		case (st_reg)
			DPS_IDLE: begin
				br_next = 1'b0;
				grant_acknowledge_next = 1'b0;
				if (arm) begin
					if (cfg_bad) begin
						cfg_err_next = 1'b1;
					end else begin
						st_next = DPS_INIT;
					end
				end
			end
			DPS_INIT: begin
				if (fire) begin
					st_next = DPS_REQ;
				end
			end
			DPS_REQ: begin
				if (!grant_acknowledge_reg) begin
					br_next = 1'b1;
				end
				if (!bus_grant_n && bus_busy_n && !grant_acknowledge_reg && (xfer_req_n == 1'b0)) begin
					grant_acknowledge_next = 1'b1;
				end
				if (grant_acknowledge_reg) begin
					br_next = 1'b0;
					st_next = cfg_reg[CFG_ENABLE_CLK] ? DPS_WAITE : DPS_XFER;
				end
			end
			DPS_WAITE: begin
				if (e_fall) begin
					st_next = DPS_XFER;
				end
			end
			DPS_XFER: begin
				as_next = 1'b1;
				ack_next = 1'b1;
				fc_next = codes_reg[2:0];
				hib_next = cfg_reg[CFG_SINGLE] && !cfg_reg[CFG_ITEM_WIDTH] && !byte_addr_odd;
				eot_next = (transfer_counter_reg == 16'h0001);
				if (as_reg && (bus_exception_code_n != 3'h7)) begin
					bus_err_next = 1'b1;
					st_next = DPS_IDLE;
					as_next = 1'b0;
					ack_next = 1'b0;
					eot_next = 1'b0;
					hib_next = 1'b0;
				end else if (as_reg && !dtack_n) begin
					dtc_next = 1'b1;
					rdata_next = periph_data_in;
					as_next = 1'b0;
					ack_next = 1'b0;
					eot_next = 1'b0;
					hib_next = 1'b0;
					transfer_counter_next = transfer_counter_reg - 16'h0001;
					if (transfer_counter_reg == 16'h0001) begin
						done_next = 1'b1;
						st_next = DPS_IDLE;
					end else if (!cfg_reg[CFG_BURST] || xfer_req_n) begin
						st_next = DPS_INIT;
					end
				end
			end
			default: st_next = DPS_IDLE;
		endcase
		// single items hand the bus back and ask for it again
		if (st_next == DPS_INIT && st_reg == DPS_XFER) begin
			st_next = DPS_REQ;
			grant_acknowledge_next = 1'b0;
		end
		// abort wins over the next state of any step; a dtc, count or steer set in the same cycle still goes out
		if (abort_ev && (st_reg != DPS_IDLE)) begin
			abort_err_next = 1'b1;
			st_next = DPS_IDLE;
			br_next = 1'b0;
			grant_acknowledge_next = 1'b0;
			as_next = 1'b0;
			ack_next = 1'b0;
			eot_next = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg_reg <= 9'h000;
			transfer_counter_reg <= COUNT_RESET;
			codes_reg <= CODES_RESET;
			abort_err_reg <= 1'b0;
			cfg_err_reg <= 1'b0;
			bus_err_reg <= 1'b0;
			done_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
			st_reg <= DPS_IDLE;
			br_reg <= 1'b0;
			grant_acknowledge_reg <= 1'b0;
			as_reg <= 1'b0;
			ack_reg <= 1'b0;
			eot_reg <= 1'b0;
			dtc_reg <= 1'b0;
			hib_reg <= 1'b0;
			fc_reg <= 3'h0;
			rdata_reg <= 16'h0000;
			pcl_prev_reg <= 1'b1;
			ecl_prev_reg <= 1'b1;
			pulse_reg <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			transfer_counter_reg <= transfer_counter_next;
			codes_reg <= codes_next;
			abort_err_reg <= abort_err_next;
			cfg_err_reg <= cfg_err_next;
			bus_err_reg <= bus_err_next;
			done_reg <= done_next;
			prdata_reg <= prdata_next;
			st_reg <= st_next;
			br_reg <= br_next;
			grant_acknowledge_reg <= grant_acknowledge_next;
			as_reg <= as_next;
			ack_reg <= ack_next;
			eot_reg <= eot_next;
			dtc_reg <= dtc_next;
			hib_reg <= hib_next;
			fc_reg <= fc_next;
			rdata_reg <= rdata_next;
			pcl_prev_reg <= peripheral_control_line_in;
			ecl_prev_reg <= peripheral_control_line_in;
			pulse_reg <= pulse_next;
		end
	end
endmodule // dps_channel
`default_nettype wire

// File: tb/dps_chk_asserts.sv
// checker: port timing of the dma channel
`default_nettype none
module dps_chk_asserts (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic peripheral_control_line_out,
	input wire logic peripheral_control_line_oe,
	input wire logic periph_ack_n,
	input wire logic end_of_transfer_n,
	input wire logic data_transfer_complete_n,
	input wire logic [15:0] periph_data_in,
	input wire logic [15:0] read_data,
	input wire logic byte_addr_odd,
	input wire logic high_lane_steer_n,
	input wire logic bus_request_out_n,
	input wire logic grant_acknowledge_n,
	input wire logic address_strobe_n,
	input wire logic [2:0] function_code_lines
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_pulse_len: assert property (peripheral_control_line_oe |->
		!peripheral_control_line_out ##1 !peripheral_control_line_oe) else $error("start pulse");
	a_tc_ack: assert property (!end_of_transfer_n |-> !periph_ack_n) else $error("eot alone");
	a_dtc_data: assert property (!data_transfer_complete_n |-> read_data == $past(periph_data_in))
		else $error("dtc data");
	a_dtc_item: assert property (!data_transfer_complete_n |-> !$past(address_strobe_n))
		else $error("dtc alone");
	a_steer_even: assert property (!high_lane_steer_n |-> !periph_ack_n && !byte_addr_odd)
		else $error("steer");
	a_req_drop: assert property ($fell(grant_acknowledge_n) |->
		!bus_request_out_n ##1 bus_request_out_n) else $error("request drop");
	a_req_hold: assert property ($rose(bus_request_out_n) |-> !grant_acknowledge_n) else $error("early");
	a_fc_hold: assert property (!address_strobe_n && !$past(address_strobe_n) |->
		$stable(function_code_lines)) else $error("fc moved");
endmodule // dps_chk_asserts
bind dps_channel dps_chk_asserts i_chk (
	.clk(clk),
	.rst_n(rst_n),
	.peripheral_control_line_out(peripheral_control_line_out),
	.peripheral_control_line_oe(peripheral_control_line_oe),
	.periph_ack_n(periph_ack_n),
	.end_of_transfer_n(end_of_transfer_n),
	.data_transfer_complete_n(data_transfer_complete_n),
	.periph_data_in(periph_data_in),
	.read_data(read_data),
	.byte_addr_odd(byte_addr_odd),
	.high_lane_steer_n(high_lane_steer_n),
	.bus_request_out_n(bus_request_out_n),
	.grant_acknowledge_n(grant_acknowledge_n),
	.address_strobe_n(address_strobe_n),
	.function_code_lines(function_code_lines)
);
`default_nettype wire

// File: tb/dps_far_model.sv
// partner: requester, arbiter and bus slave facing the channel
`default_nettype none
module dps_far_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic req_en,
	input wire logic exc,
	input wire logic abort,
	input wire logic eclk_on,
	input wire logic bus_request_out_n,
	input wire logic end_of_transfer_n,
	input wire logic address_strobe_n,
	output logic xfer_req_n,
	output logic bus_grant_n,
	output logic bus_busy_n,
	output logic dtack_n,
	output logic [15:0] periph_data_in,
	output logic [2:0] bus_exception_code_n,
	output logic peripheral_control_line_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] waited;
	logic [1:0] ediv;
	logic done_seen;
	always_ff @(posedge clk) begin
		ediv <= rst_n ? ediv + 2'h1 : 2'h0;
		// new data every cycle, so a late latch never matches
		periph_data_in <= rst_n ? periph_data_in * 16'h0005 + 16'h3b21 : 16'h1234;
		bus_grant_n <= bus_request_out_n;
		waited <= address_strobe_n ? 4'h0 : waited + 4'h1;
		done_seen <= req_en && (done_seen || !end_of_transfer_n);
	end
	assign xfer_req_n = !req_en || done_seen || !end_of_transfer_n;
	assign dtack_n = address_strobe_n || waited < (slow ? 4'h3 : 4'h0);
	assign bus_busy_n = 1'h1;
	assign bus_exception_code_n = exc && !address_strobe_n ? 3'h5 : 3'h7;
	assign peripheral_control_line_in = eclk_on ? ediv[1] : !abort;
endmodule // dps_far_model
`default_nettype wire

// File: tb/testbench.sv
// testbench: registers, start delay and transfers of the dma channel
`default_nettype none
module testbench
	import dps_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = '0, rst_n = '0, psel = '0, penable = '0, pwrite = '0, byte_addr_odd = '0, diagonal_word = '0;
	logic slow = '0, req_en = '0, exc = '0, abort = '0, eclk_on = '0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, peripheral_control_line_in, peripheral_control_line_out, peripheral_control_line_oe;
	logic xfer_req_n, periph_ack_n, end_of_transfer_n, data_transfer_complete_n, high_lane_steer_n, busy;
	logic bus_request_out_n, bus_grant_n, bus_busy_n, grant_acknowledge_n, address_strobe_n, dtack_n;
	logic [15:0] periph_data_in, read_data;
	logic [2:0] bus_exception_code_n, function_code_lines;
	int dly [3] = '{START_DLY_NOCHAIN, START_DLY_ARRAY, START_DLY_LINKED};
	int fail_count = 0, n_checks = 0, cyc = 0, seed = 32'h67c70377, items, tail, steer, exp_fc, i, n, k;
	dps_channel i_dut (
		.clk(clk),
		.rst_n(rst_n),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.peripheral_control_line_in(peripheral_control_line_in),
		.peripheral_control_line_out(peripheral_control_line_out),
		.peripheral_control_line_oe(peripheral_control_line_oe),
		.xfer_req_n(xfer_req_n),
		.periph_ack_n(periph_ack_n),
		.end_of_transfer_n(end_of_transfer_n),
		.data_transfer_complete_n(data_transfer_complete_n),
		.periph_data_in(periph_data_in),
		.read_data(read_data),
		.byte_addr_odd(byte_addr_odd),
		.diagonal_word(diagonal_word),
		.high_lane_steer_n(high_lane_steer_n),
		.bus_request_out_n(bus_request_out_n),
		.bus_grant_n(bus_grant_n),
		.bus_busy_n(bus_busy_n),
		.grant_acknowledge_n(grant_acknowledge_n),
		.address_strobe_n(address_strobe_n),
		.dtack_n(dtack_n),
		.bus_exception_code_n(bus_exception_code_n),
		.function_code_lines(function_code_lines),
		.busy(busy)
	);
	dps_far_model i_far (
		.clk(clk),
		.rst_n(rst_n),
		.slow(slow),
		.req_en(req_en),
		.exc(exc),
		.abort(abort),
		.eclk_on(eclk_on),
		.bus_request_out_n(bus_request_out_n),
		.end_of_transfer_n(end_of_transfer_n),
		.address_strobe_n(address_strobe_n),
		.xfer_req_n(xfer_req_n),
		.bus_grant_n(bus_grant_n),
		.bus_busy_n(bus_busy_n),
		.dtack_n(dtack_n),
		.periph_data_in(periph_data_in),
		.bus_exception_code_n(bus_exception_code_n),
		.peripheral_control_line_in(peripheral_control_line_in)
	);
	initial forever #25 clk = ~clk;
	task automatic chk(input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		// read data is taken at the edge that sees pready high
		rd = prdata;
		chk({pready, pslverr}, 32'h2);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic go(input logic [31:0] cfg, input logic [31:0] cnt);
		req_en <= 1'h0;
		apb(1'h1, ADDR_CTRL, 32'h2);
		apb(1'h1, ADDR_COUNT, cnt);
		apb(1'h1, ADDR_CFG, cfg);
		items = 0;
		tail = -1;
		steer = 0;
		req_en <= 1'h1;
		apb(1'h1, ADDR_CTRL, 32'h1);
	endtask
	task automatic settle(input logic [31:0] st);
		n = 0;
		do apb(1'h0, ADDR_STATUS, '0); while (rd[3:0] == 4'h0 && ++n < 400);
		chk(rd, st);
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			conclude();
		end
	end
	always @(posedge clk) begin
		if (!end_of_transfer_n) tail = items;
		if (!data_transfer_complete_n) items++;
		if (!high_lane_steer_n) steer = 1;
		if (!address_strobe_n) chk(function_code_lines, exp_fc);
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		apb(1'h1, 8'h20, '1);
		for (i = 0; i < 4; i++) begin
			apb(1'h0, i < 3 ? ADDR_COUNT + 8'(i * 4) : 8'h20, '0);
			chk(rd, '0);
		end
		for (i = 0; i < 3; i++) begin
			exp_fc = {$random(seed)} % 7;
			slow <= i[0];
			apb(1'h1, ADDR_CODES, exp_fc);
			apb(1'h0, ADDR_CODES, '0);
			chk(rd, exp_fc);
			go(32'(PCL_START) | 32'(i ? i + 1 : 0) << CFG_CHAIN_LO, 1);
			for (n = 1; peripheral_control_line_oe !== 1'h1 && n < 100; n++) @(posedge clk) #1;
			chk(n, dly[i] + 1);
			settle(1);
			chk(tail, 0);
			chk(items, 1);
		end
		k = {$random(seed)} % 4 + 2;
		go(32'h1 << CFG_BURST | 32'h1 << CFG_SINGLE, k);
		settle(1);
		chk(items, k);
		chk(tail, k - 1);
		chk(steer, 1);
		byte_addr_odd <= 1'h1;
		eclk_on <= 1'h1;
		go(32'h1 << CFG_SINGLE | 32'h1 << CFG_ENABLE_CLK, 2);
		settle(1);
		chk(items, 2);
		chk(steer, 0);
		byte_addr_odd <= 1'h0;
		eclk_on <= 1'h0;
		go(32'h1 << CFG_SINGLE | 32'h1 << CFG_ITEM_WIDTH, 1);
		settle(4);
		diagonal_word <= 1'h1;
		go(32'h3 << CFG_ITEM_WIDTH, 1);
		settle(4);
		chk(items, 0);
		diagonal_word <= 1'h0;
		go(32'(PCL_ABORT) | 32'h1 << CFG_BURST, 8);
		for (n = 0; periph_ack_n !== 1'h0 && n < 500; n++) @(posedge clk) #1;
		@(posedge clk);
		abort <= 1'h1;
		@(posedge clk);
		abort <= 1'h0;
		settle(2);
		chk(busy, '0);
		exc <= 1'h1;
		go('0, 4);
		settle(8);
		exc <= 1'h0;
		conclude();
	end
endmodule // testbench
`default_nettype wire
